// file: include/sdh_consts.svh
`ifndef SDH_CONSTS_SVH
`define SDH_CONSTS_SVH

// Channel count and counter widths
`define SDH_NUM_CH        9
`define SDH_CNT_W         19
`define SDH_ACK_CNT_W     5
`define SDH_HOST_CNT_W    7

// Core clock rate
`define SDH_CLK_MHZ       20

// Clean interval after make and after break, in milliseconds
`define SDH_CLEAN_MS      20
`define SDH_CLEAN_CYC     ((`SDH_CLEAN_MS * `SDH_CLK_MHZ * 1000))

// Host acknowledge pulse length, in nanoseconds (rounded up)
`define SDH_ACK_NS        5000
`define SDH_ACK_CYC       ((`SDH_ACK_NS * `SDH_CLK_MHZ + 999) / 1000)

// Least low time that the device accepts as an acknowledge (rounded up)
`define SDH_ACK_MIN_NS    1000
`define SDH_ACK_MIN_CYC   ((`SDH_ACK_MIN_NS * `SDH_CLK_MHZ + 999) / 1000)

// Longest time from acknowledge to line held low, in microseconds (rounded down)
`define SDH_RESP_US       20
`define SDH_RESP_CYC      ((`SDH_RESP_US * `SDH_CLK_MHZ))

// Reset values
`define SDH_LINE_RST      1'b0
`define SDH_OE_N_RST      1'b0

`endif

// file: include/sdh_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdh_consts.svh"

// Wired request/acknowledge lines, one per channel
interface sdh_link_if;
  logic [`SDH_NUM_CH-1:0] dev_out;
  logic [`SDH_NUM_CH-1:0] dev_oe_n;
  logic [`SDH_NUM_CH-1:0] host_out;
  logic [`SDH_NUM_CH-1:0] host_oe_n;
  logic [`SDH_NUM_CH-1:0] request_ack_line;

  // A driven low wins, else a driven high, else the line rests low
  assign request_ack_line = ~((~host_oe_n & ~host_out) | (~dev_oe_n & ~dev_out))
                            & ((~host_oe_n & host_out) | (~dev_oe_n & dev_out));

  modport device (
    output dev_out,
    output dev_oe_n,
    input  request_ack_line
  );

  modport host (
    output host_out,
    output host_oe_n,
    input  request_ack_line
  );
endinterface
`default_nettype wire

// file: include/sdh_pkg.sv
`include "sdh_consts.svh"

package sdh_pkg;

  // Channel phases of one switch cycle
  typedef enum logic [1:0] {
    SDH_IDLE,
    SDH_MAKE,
    SDH_HELD,
    SDH_BREAK
  } sdh_ch_state_t;

  // Host acknowledge sequencer phases
  typedef enum logic [0:0] {
    SDH_H_IDLE,
    SDH_H_DRIVE
  } sdh_host_state_t;

  // All state of one device channel
  typedef struct packed {
    sdh_ch_state_t              state;
    logic [`SDH_CNT_W-1:0]      cnt;
    logic [`SDH_ACK_CNT_W-1:0]  ack_cnt;
    logic                       acked;
    logic                       line_out;
    logic                       clean;
    logic                       sw_s1;
    logic                       sw_s2;
    logic                       ln_s1;
    logic                       ln_s2;
    logic                       last_closed;
  } sdh_ch_t;

  // All state of the host end
  typedef struct packed {
    sdh_host_state_t            state;
    logic [`SDH_HOST_CNT_W-1:0] cnt;
    logic [`SDH_NUM_CH-1:0]     drive;
    logic [`SDH_NUM_CH-1:0]     ln_s1;
    logic [`SDH_NUM_CH-1:0]     ln_s2;
    logic [`SDH_NUM_CH-1:0]     pending;
    logic                       busy;
  } sdh_host_t;

endpackage

// file: tb/sdh_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdh_consts.svh"

// Watches the wired lines between both ends, channel 0 in depth
module sdh_link_checker #(
  parameter int CLEAN_CYC = `SDH_CLEAN_CYC
) (
  // Clock and reset
  input wire logic                   core_clk_in,
  input wire logic                   rstn_in,
  // Link signals
  input wire logic [`SDH_NUM_CH-1:0] dev_out,
  input wire logic [`SDH_NUM_CH-1:0] dev_oe_n,
  input wire logic [`SDH_NUM_CH-1:0] host_out,
  input wire logic [`SDH_NUM_CH-1:0] host_oe_n,
  input wire logic [`SDH_NUM_CH-1:0] request_ack_line
);
  logic [19:0] low_q;
  logic [19:0] high_q;

  // Saturating run lengths of low and high device drive
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_q  <= 20'(CLEAN_CYC);
      high_q <= 20'h0_0000;
    end else begin
      low_q  <= dev_out[0] ? 20'h0_0000 : low_q + 20'(low_q < 20'(CLEAN_CYC));
      high_q <= !dev_out[0] ? 20'h0_0000 : high_q + 20'(high_q < 20'(CLEAN_CYC));
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_dev_drives_line: assert property (dev_oe_n == '0)
    else $error("device released its line");
  a_host_low_only: assert property (host_out == '0)
    else $error("host drove its line high");
  a_ack_pulse_len: assert property ($fell(host_oe_n[0]) |-> (!host_oe_n[0] throughout ##99 1) ##1 host_oe_n[0])
    else $error("acknowledge pulse length wrong");
  a_ack_response: assert property ($fell(host_oe_n[0]) && dev_out[0] |-> ##[1:400] !dev_out[0])
    else $error("device slow to end acked cycle");
  a_ack_latched: assert property ($rose(host_oe_n[0]) |-> !dev_out[0] && !request_ack_line[0])
    else $error("line not held low after acknowledge");
  a_rise_line_free: assert property ($rose(dev_out[0]) |-> request_ack_line[0])
    else $error("line not high on new request");
  a_break_clean: assert property ($rose(dev_out[0]) |-> low_q >= 20'(CLEAN_CYC))
    else $error("new cycle before clean release interval");
  a_make_clean: assert property ($fell(dev_out[0]) && host_oe_n[0] |-> high_q >= 20'(CLEAN_CYC))
    else $error("release passed before make interval");

  // Main scenarios
  c_request: cover property ($rose(dev_out[0]));
  c_ack: cover property ($fell(host_oe_n[0]) && dev_out[0]);
  c_release: cover property ($fell(dev_out[0]) && host_oe_n[0]);
endmodule // sdh_link_checker
`default_nettype wire

// file: tb/switch_debounce_handshake_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdh_consts.svh"

// Device and host ends joined back to back
module switch_debounce_handshake_tb;
  localparam int CLEAN = 50;
  logic       core_clk;
  logic       rstn;
  logic [8:0] switch_n;
  logic [8:0] ack_req;
  logic [8:0] clean;
  logic [8:0] pending;
  logic       busy;
  int         num_errors;
  int         checks;
  int         i;

  sdh_link_if link ();
  sdh_device #(.CLEAN_CYC(CLEAN)) i_sdh_device (.core_clk_in(core_clk), .rstn_in(rstn),
    .switch_n_in(switch_n), .clean_out(clean), .link(link));
  sdh_host i_sdh_host (.core_clk_in(core_clk), .rstn_in(rstn), .ack_req_in(ack_req),
    .pending_out(pending), .busy_out(busy), .link(link));
  sdh_link_checker #(.CLEAN_CYC(CLEAN)) i_sdh_link_checker (.core_clk_in(core_clk), .rstn_in(rstn),
    .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n), .host_out(link.host_out),
    .host_oe_n(link.host_oe_n), .request_ack_line(link.request_ack_line));

  // Compare a seen value with its expectation
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Let n edges pass, then settle just after the last
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  // Set one contact, closed pulls the input low, and hold it
  task automatic write_sw(input int ch, input logic closed, input int hold);
    switch_n[ch] = ~closed;
    step(hold);
  endtask

  // Read the resolved line levels
  task automatic read_line(input logic [8:0] exp);
    check("line", link.request_ack_line, exp);
  endtask

  // Chatter around a resting level, ending at it
  task automatic bounce(input int ch, input int n, input logic lvl);
    repeat (n) begin
      write_sw(ch, ~lvl, 2);
      write_sw(ch, lvl, 3);
    end
  endtask

  // Pulse an acknowledge request and wait for the host to finish
  task automatic ack(input logic [8:0] chs);
    ack_req = chs;
    step(1);
    ack_req = 9'h000;
    for (i = 0; i < 300 && busy !== 1'b0; i++) step(1);
  endtask

  // Print counts and the verdict, then stop
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Free running core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Cut a hang short
  initial begin
    #500_000;
    num_errors++;
    give_verdict();
  end

  // Test sequence
  initial begin
    rstn = 1'b0;
    switch_n = 9'h1ff;
    ack_req = 9'h000;
    num_errors = 0;
    checks = 0;
    step(3);
    rstn = 1'b1;
    step(2);
    write_sw(0, 1'b1, 2);
    read_line(9'h000);
    step(1);
    read_line(9'h001);
    bounce(0, 4, 1'b1);
    read_line(9'h001);
    step(60);
    check("clean", clean, 9'h001);
    write_sw(0, 1'b0, 3);
    read_line(9'h000);
    bounce(0, 4, 1'b0);
    write_sw(0, 1'b1, 100);
    read_line(9'h000);
    write_sw(0, 1'b0, 40);
    write_sw(0, 1'b1, 10);
    read_line(9'h000);
    write_sw(0, 1'b0, 60);
    write_sw(0, 1'b1, 3);
    read_line(9'h001);
    $display("Test make and break done");
    step(5);
    check("pending", pending, 9'h001);
    ack_req = 9'h001;
    step(1);
    ack_req = 9'h000;
    check("busy", {8'h00, busy}, 9'h001);
    for (i = 0; i < 300 && busy !== 1'b0; i++) step(1);
    check("pulse", 9'(i), 9'd100);
    step(2);
    read_line(9'h000);
    check("clean", clean, 9'h001);
    step(100);
    read_line(9'h000);
    write_sw(0, 1'b0, 3);
    check("clean", clean, 9'h000);
    write_sw(0, 1'b0, 60);
    write_sw(0, 1'b1, 3);
    read_line(9'h001);
    write_sw(0, 1'b0, 60);
    read_line(9'h000);
    $display("Test acknowledge done");
    switch_n = 9'h0f7;
    step(3);
    read_line(9'h108);
    step(5);
    ack(9'h10a);
    step(2);
    read_line(9'h000);
    step(3);
    check("pending", pending, 9'h000);
    $display("Test multi channel done");
    rstn = 1'b0;
    step(1);
    check("clean", clean, 9'h000);
    read_line(9'h000);
    rstn = 1'b1;
    step(3);
    read_line(9'h108);
    $display("Test reset done");
    give_verdict();
  end
endmodule // switch_debounce_handshake_tb
`default_nettype wire

// file: verilog/sdh_device.sv
// Summary of operation
// - One switch input, one line per channel
// - Raise line at once on closure
// - Drop line at once on release after a clean make
// - Hide make and break bounce
// - No new cycle before break debounce ends
// - Without acknowledge, line mirrors clean switch
// - Sense host low pulse on active line
// - Host acknowledges with about 5 us low
// - Acknowledge latches line low while closed
// - Line held low within 20 us
// - Debouncing continues after acknowledge
// - New closure only after 20 ms clean release
// - Host reads high as pending request
// - Host drives pin low about 5 us
// - Host then returns pin to input
`timescale 1ns/1ps
`default_nettype none
`include "sdh_consts.svh"

// One debounce channel with acknowledge sensing
module sdh_channel #(
  parameter int CLEAN_CYC = `SDH_CLEAN_CYC
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  // Switch side, low while closed
  input  wire logic switch_n_in,
  // Line side
  input  wire logic line_in,
  output logic      line_out,
  // Clean switch level, high while closed
  output logic      clean_out
);

  localparam logic [`SDH_CNT_W-1:0]     CLEAN_LAST = `SDH_CNT_W'(CLEAN_CYC - 1);
  localparam logic [`SDH_ACK_CNT_W-1:0] ACK_LAST   = `SDH_ACK_CNT_W'(`SDH_ACK_MIN_CYC - 1);

  sdh_pkg::sdh_ch_t ch_q;
  sdh_pkg::sdh_ch_t ch_d;
  logic             closed;
  logic             ack_seen;
  logic             ack_low;
  logic             in_cycle;

  // Synchronised switch level and acknowledge filter result
  assign closed   = ~ch_q.sw_s2;
  assign ack_seen = (ch_q.ack_cnt == ACK_LAST);
  assign ack_low  = ch_q.line_out && !ch_q.ln_s2 && !ch_q.acked;

  // An acknowledge only counts while a cycle is open
  assign in_cycle = (ch_q.state == sdh_pkg::SDH_MAKE) || (ch_q.state == sdh_pkg::SDH_HELD);

  // Next-state logic for one channel
  always_comb begin
    ch_d       = ch_q;
    // Two-stage synchronisers for switch and line
    ch_d.sw_s1 = switch_n_in;
    ch_d.sw_s2 = ch_q.sw_s1;
    ch_d.ln_s1 = line_in;
    ch_d.ln_s2 = ch_q.ln_s1;

    // Level seen last, so that make debounce sees every change
    ch_d.last_closed = closed;

    // Count low samples while driving high; stale samples after a rise stay short of the limit
    if (ack_low) begin
      if (!ack_seen) begin
        ch_d.ack_cnt = ch_q.ack_cnt + `SDH_ACK_CNT_W'(1);
      end
    end else begin
      ch_d.ack_cnt = '0;
    end

    case (ch_q.state)
      sdh_pkg::SDH_IDLE: begin
        ch_d.cnt = '0;
        if (closed) begin
          ch_d.state = sdh_pkg::SDH_MAKE;
          ch_d.clean = 1'b1;
        end
      end
      sdh_pkg::SDH_MAKE: begin
        // Each change of level during make is bounce and restarts the clean count
        if (closed != ch_q.last_closed) begin
          ch_d.cnt = '0;
        end else if (ch_q.cnt != CLEAN_LAST) begin
          ch_d.cnt = ch_q.cnt + `SDH_CNT_W'(1);
        end else if (closed) begin
          // Clean make: hold until the first open
          ch_d.state = sdh_pkg::SDH_HELD;
          ch_d.cnt   = '0;
        end else begin
          // Open for a whole clean interval: a release, so the line must not stay high
          ch_d.state = sdh_pkg::SDH_BREAK;
          ch_d.clean = 1'b0;
          ch_d.cnt   = '0;
        end
      end
      sdh_pkg::SDH_HELD: begin
        // First open after a clean make ends the cycle
        if (!closed) begin
          ch_d.state = sdh_pkg::SDH_BREAK;
          ch_d.clean = 1'b0;
          ch_d.cnt   = '0;
        end
      end
      sdh_pkg::SDH_BREAK: begin
        // Closures during break are bounce and stretch the interval
        if (closed) begin
          ch_d.cnt = '0;
        end else if (ch_q.cnt == CLEAN_LAST) begin
          ch_d.state = sdh_pkg::SDH_IDLE;
          ch_d.cnt   = '0;
        end else begin
          ch_d.cnt = ch_q.cnt + `SDH_CNT_W'(1);
        end
      end
      default: begin
        ch_d.state = sdh_pkg::SDH_IDLE;
      end
    endcase

    // Acknowledge latches low; debouncing above runs on regardless
    if (ack_seen && in_cycle) begin
      ch_d.acked = 1'b1;
    end else if (ch_q.state == sdh_pkg::SDH_BREAK && ch_d.state == sdh_pkg::SDH_IDLE) begin
      ch_d.acked = 1'b0;
    end

    // Line high through make and hold unless acknowledged
    ch_d.line_out = (ch_d.state == sdh_pkg::SDH_MAKE || ch_d.state == sdh_pkg::SDH_HELD)
                    && !ch_d.acked;
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ch_q.state    <= sdh_pkg::SDH_IDLE;
      ch_q.cnt      <= '0;
      ch_q.ack_cnt  <= '0;
      ch_q.acked    <= 1'b0;
      ch_q.line_out <= `SDH_LINE_RST;
      ch_q.clean    <= 1'b0;
      ch_q.sw_s1    <= 1'b1;
      ch_q.sw_s2    <= 1'b1;
      ch_q.ln_s1    <= 1'b0;
      ch_q.ln_s2    <= 1'b0;
      ch_q.last_closed <= 1'b0;
    end else begin
      ch_q <= ch_d;
    end
  end

  // Channel outputs straight from the state register
  assign line_out  = ch_q.line_out;
  assign clean_out = ch_q.clean;

endmodule // sdh_channel

// Device end: independent debounce channels on wired lines
module sdh_device #(
  parameter int CLEAN_CYC = `SDH_CLEAN_CYC
) (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rstn_in,
  // Switch inputs, low while closed
  input  wire logic [`SDH_NUM_CH-1:0] switch_n_in,
  // Clean switch levels
  output logic      [`SDH_NUM_CH-1:0] clean_out,
  // Line side
  sdh_link_if.device                  link
);

  logic [`SDH_NUM_CH-1:0] line_q;
  logic [`SDH_NUM_CH-1:0] oe_n_q;

  // One channel per switch, each with its own line
  for (genvar i = 0; i < `SDH_NUM_CH; i++) begin : g_ch
    sdh_channel #(
      .CLEAN_CYC (CLEAN_CYC)
    ) u_ch (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .switch_n_in (switch_n_in[i]),
      .line_in     (link.request_ack_line[i]),
      .line_out    (line_q[i]),
      .clean_out   (clean_out[i])
    );
  end

  // The device always drives its lines; a host low overrides
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      oe_n_q <= {`SDH_NUM_CH{`SDH_OE_N_RST}};
    end else begin
      oe_n_q <= {`SDH_NUM_CH{`SDH_OE_N_RST}};
    end
  end

  // Registered drive levels and enables onto the wired lines
  assign link.dev_out  = line_q;
  assign link.dev_oe_n = oe_n_q;

endmodule // sdh_device
`default_nettype wire

// file: verilog/sdh_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdh_consts.svh"

// Host end: reports pending requests and pulses acknowledges
module sdh_host (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rstn_in,
  // User side
  input  wire logic [`SDH_NUM_CH-1:0] ack_req_in,
  output logic      [`SDH_NUM_CH-1:0] pending_out,
  output logic                        busy_out,
  // Line side
  sdh_link_if.host                    link
);

  localparam logic [`SDH_HOST_CNT_W-1:0] ACK_LAST = `SDH_HOST_CNT_W'(`SDH_ACK_CYC - 1);

  sdh_pkg::sdh_host_t h_q;
  sdh_pkg::sdh_host_t h_d;
  logic [`SDH_NUM_CH-1:0] take;

  // Only channels that show a request are acknowledged
  assign take = ack_req_in & h_q.pending;

  // Next-state logic
  always_comb begin
    h_d         = h_q;
    h_d.ln_s1   = link.request_ack_line;
    h_d.ln_s2   = h_q.ln_s1;
    // High line means a request is pending
    h_d.pending = h_q.ln_s2;
    case (h_q.state)
      sdh_pkg::SDH_H_IDLE: begin
        h_d.cnt = '0;
        if (take != '0) begin
          h_d.state = sdh_pkg::SDH_H_DRIVE;
          h_d.drive = take;
          h_d.busy  = 1'b1;
        end
      end
      sdh_pkg::SDH_H_DRIVE: begin
        // Hold low for the pulse length, then release to input
        if (h_q.cnt == ACK_LAST) begin
          h_d.state = sdh_pkg::SDH_H_IDLE;
          h_d.drive = '0;
          h_d.busy  = 1'b0;
          h_d.cnt   = '0;
        end else begin
          h_d.cnt = h_q.cnt + `SDH_HOST_CNT_W'(1);
        end
      end
      default: begin
        h_d.state = sdh_pkg::SDH_H_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      h_q.state   <= sdh_pkg::SDH_H_IDLE;
      h_q.cnt     <= '0;
      h_q.drive   <= '0;
      h_q.ln_s1   <= '0;
      h_q.ln_s2   <= '0;
      h_q.pending <= '0;
      h_q.busy    <= 1'b0;
    end else begin
      h_q <= h_d;
    end
  end

  assign link.host_out  = '0;
  assign link.host_oe_n = ~h_q.drive;
  assign pending_out    = h_q.pending;
  assign busy_out       = h_q.busy;

endmodule // sdh_host
`default_nettype wire
